// >>> pkg/wps_pkg.sv
// constants and carrier types of the path status overhead block
`default_nettype none
package wps_pkg;
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned LCD_SET_US = 3000;
  localparam int unsigned LCD_CLR_US = 1000;
  localparam int unsigned LCD_SET_CYC = LCD_SET_US * CLK_MHZ;
  localparam int unsigned LCD_CLR_CYC = LCD_CLR_US * CLK_MHZ;
  localparam int unsigned LCD_CW = 20;
  localparam int unsigned DW = 16;
  localparam int unsigned AW = 8;
  localparam logic [3:0] PERSIST_FRAMES = 4'ha;
  localparam logic [3:0] REI_MAX = 4'h8;
  localparam logic [AW-1:0] A_CTRL = 8'h00;
  localparam logic [AW-1:0] A_USER = 8'h04;
  localparam logic [AW-1:0] A_TANDEM = 8'h08;
  localparam logic [AW-1:0] A_GROWTH = 8'h0c;
  localparam logic [AW-1:0] A_STAT = 8'h10;
  localparam logic [AW-1:0] A_PEND = 8'h14;
  localparam logic [AW-1:0] A_MASKA = 8'h18;
  localparam logic [AW-1:0] A_MASKB = 8'h1c;
  localparam int unsigned C_RXFMT = 0;
  localparam int unsigned C_TXFMT = 1;
  localparam int unsigned C_TIM = 2;
  localparam logic [2:0] CTRL_RST = 3'h3;
  localparam int unsigned E_RDI = 0;
  localparam int unsigned E_PAY = 1;
  localparam int unsigned E_SRV = 2;
  localparam int unsigned E_CON = 3;
  localparam int unsigned E_LCD = 4;
  localparam int unsigned NEV = 5;
  localparam int unsigned G1_RDI_BIT = 3;
  localparam logic [2:0] CODE_NONE = 3'h0;
  localparam logic [2:0] CODE_RDI = 3'h4;
  localparam logic [2:0] CODE_OK = 3'h1;
  localparam logic [2:0] CODE_PAY = 3'h2;
  localparam logic [2:0] CODE_SRV = 3'h5;
  localparam logic [2:0] CODE_CON = 3'h6;

  typedef struct packed {
    logic server;
    logic unequipped;
    logic label_mismatch;
  } wps_ne_s;

  typedef struct packed {
    logic [7:0] g1;
    logic [7:0] f2;
    logic [7:0] h4;
    logic [7:0] z3;
    logic [7:0] z4;
    logic [7:0] n1;
  } wps_tx_oh_s;
endpackage : wps_pkg
`default_nettype wire

// >>> design/wps_path_status.sv
// path status octet handling, path overhead insertion and delineation loss
`default_nettype none
module wps_path_status
  import wps_pkg::*;
#(
  parameter int unsigned P_SET_CYC = LCD_SET_CYC,
  parameter int unsigned P_CLR_CYC = LCD_CLR_CYC
) (
  input wire logic I_CLK,
  input wire logic I_RST_N,
  input wire logic [AW-1:0] I_ADDR,
  input wire logic [DW-1:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [DW-1:0] O_RDATA,
  input wire logic I_RX_G1_VALID,
  input wire logic [7:0] I_RX_G1,
  input wire logic I_REI_VALID,
  input wire logic [3:0] I_REI_CNT,
  input wire logic I_TX_FRAME,
  input wire wps_ne_s I_NE_DEFECT,
  input wire logic I_PCS_LCD,
  input wire logic I_PCS_SYNC,
  output wps_tx_oh_s O_TX_OH,
  output logic O_LCD_REPORT,
  output logic O_IRQ_A,
  output logic O_IRQ_B
);

  typedef struct packed {
    logic [2:0] ctrl;
    logic [7:0] f2;
    logic [7:0] h4;
    logic [7:0] n1;
    logic [7:0] z3;
    logic [7:0] z4;
    logic [NEV-1:0] mask_a;
    logic [NEV-1:0] mask_b;
    logic [NEV-1:0] pend;
    logic lat_pay;
    logic lat_srv;
    logic lat_lcd;
    logic rdi_def;
    logic [2:0] def_code;
    logic [2:0] cand;
    logic [3:0] on_cnt;
    logic [3:0] off_cnt;
    logic rei_full;
    logic [3:0] rei_val;
    logic [7:0] g1;
    logic lcd_def;
    logic lcd_prev;
    logic [LCD_CW-1:0] lcd_cnt;
    logic sync_seen;
    logic [DW-1:0] rdata;
    logic irq_a;
    logic irq_b;
  } wps_state_s;

  localparam logic [LCD_CW-1:0] SET_CNT = LCD_CW'(P_SET_CYC);
  localparam logic [LCD_CW-1:0] CLR_CNT = LCD_CW'(P_CLR_CYC - 1);

  wps_state_s s;
  wps_state_s next_s;

  // connectivity event rides on the remote defect mask
  function automatic logic [NEV-1:0] wps_mask_ext(input logic [NEV-1:0] m);
    logic [NEV-1:0] r;
    r = m;
    r[E_CON] = m[E_RDI];
    return r;
  endfunction : wps_mask_ext

  logic rx_fmt;
  logic tx_fmt;
  logic [2:0] rx_code;
  logic present;
  logic [2:0] cand;
  logic declare;
  logic con_live;
  logic rd_stat;
  logic rd_pend;
  logic push;
  logic [2:0] tx_code;
  logic [3:0] rei_in;

  always_comb begin
    rx_fmt = s.ctrl[C_RXFMT];
    tx_fmt = s.ctrl[C_TXFMT];
    rx_code = I_RX_G1[G1_RDI_BIT:1];
    con_live = s.rdi_def && (s.def_code == CODE_CON);
    rd_stat = I_RD && (I_ADDR == A_STAT);
    rd_pend = I_RD && (I_ADDR == A_PEND);
    rei_in = (I_REI_CNT > REI_MAX) ? REI_MAX : I_REI_CNT;
    if (rx_fmt) begin
      present = (rx_code == CODE_PAY) || (rx_code == CODE_SRV) || (rx_code == CODE_CON);
      cand = rx_code;
    end else begin
      present = I_RX_G1[G1_RDI_BIT];
      cand = CODE_RDI;
    end
    // priority 1 server, 2 connectivity, 3 payload, 4 none
    if (tx_fmt) begin
      if (I_NE_DEFECT.server) begin
        tx_code = CODE_SRV;
      end else if (I_NE_DEFECT.unequipped || s.ctrl[C_TIM]) begin
        tx_code = CODE_CON;
      end else if (I_NE_DEFECT.label_mismatch || s.lcd_def) begin
        tx_code = CODE_PAY;
      end else begin
        tx_code = CODE_OK;
      end
    end else begin
      tx_code = I_NE_DEFECT.server ? CODE_RDI : CODE_NONE;
    end
    push = I_REI_VALID && (!s.rei_full || I_TX_FRAME);
    declare = 1'b0;
    next_s = s;

    // register writes
    if (I_WR) begin
      case (I_ADDR)
        A_CTRL: begin
          next_s.ctrl = I_WDATA[2:0];
        end
        A_USER: begin
          next_s.f2 = I_WDATA[7:0];
          next_s.h4 = I_WDATA[15:8];
        end
        A_TANDEM: begin
          next_s.n1 = I_WDATA[7:0];
        end
        A_GROWTH: begin
          next_s.z3 = I_WDATA[7:0];
          next_s.z4 = I_WDATA[15:8];
        end
        A_MASKA: begin
          next_s.mask_a = I_WDATA[NEV-1:0] & ~(NEV'(1) << E_CON);
        end
        A_MASKB: begin
          next_s.mask_b = I_WDATA[NEV-1:0] & ~(NEV'(1) << E_CON);
        end
        default: begin
        end
      endcase
    end

    // read data, one cycle later
    case (I_ADDR)
      A_CTRL: next_s.rdata = DW'(s.ctrl);
      A_USER: next_s.rdata = {s.h4, s.f2};
      A_TANDEM: next_s.rdata = DW'(s.n1);
      A_GROWTH: next_s.rdata = {s.z4, s.z3};
      A_STAT: next_s.rdata = DW'({s.lat_lcd, con_live, s.lat_srv, s.lat_pay, s.rdi_def});
      A_PEND: next_s.rdata = DW'(s.pend);
      A_MASKA: next_s.rdata = DW'(s.mask_a);
      A_MASKB: next_s.rdata = DW'(s.mask_b);
      default: next_s.rdata = '0;
    endcase
    if (!I_RD) begin
      next_s.rdata = '0;
    end

    // clear on read first so that a same-cycle set wins
    if (rd_stat) begin
      next_s.lat_pay = 1'b0;
      next_s.lat_srv = 1'b0;
      next_s.lat_lcd = 1'b0;
    end
    if (rd_pend) begin
      next_s.pend = '0;
    end

    // receive defect persistence
    if (I_RX_G1_VALID) begin
      if (present) begin
        next_s.off_cnt = '0;
        if (cand == s.cand) begin
          next_s.on_cnt = (s.on_cnt == PERSIST_FRAMES) ? PERSIST_FRAMES : s.on_cnt + 4'h1;
        end else begin
          next_s.on_cnt = 4'h1;
          next_s.cand = cand;
        end
        declare = (next_s.on_cnt == PERSIST_FRAMES) && !(s.rdi_def && s.def_code == cand);
      end else begin
        next_s.on_cnt = '0;
        next_s.off_cnt = (s.off_cnt == PERSIST_FRAMES) ? PERSIST_FRAMES : s.off_cnt + 4'h1;
        if (next_s.off_cnt == PERSIST_FRAMES) begin
          next_s.rdi_def = 1'b0;
        end
      end
    end
    if (declare) begin
      next_s.rdi_def = 1'b1;
      next_s.def_code = cand;
      next_s.pend[E_RDI] = 1'b1;
      if (cand == CODE_PAY) begin
        next_s.lat_pay = 1'b1;
        next_s.pend[E_PAY] = 1'b1;
      end
      if (cand == CODE_SRV) begin
        next_s.lat_srv = 1'b1;
        next_s.pend[E_SRV] = 1'b1;
      end
      if (cand == CODE_CON) begin
        next_s.pend[E_CON] = 1'b1;
      end
    end

    // delineation loss from the coding layer
    next_s.lcd_prev = I_PCS_LCD;
    if (I_PCS_LCD != s.lcd_prev) begin
      next_s.lcd_cnt = '0;
    end else if (s.lcd_cnt < SET_CNT) begin
      next_s.lcd_cnt = s.lcd_cnt + LCD_CW'(1);
    end
    if (I_PCS_SYNC) begin
      next_s.sync_seen = 1'b1;
    end
    if (I_PCS_LCD) begin
      next_s.lat_lcd = 1'b1;
      next_s.pend[E_LCD] = 1'b1;
      if (s.lcd_prev && s.lcd_cnt == SET_CNT) begin
        next_s.lcd_def = 1'b1;
      end
    end else if (!s.lcd_prev && s.lcd_cnt >= CLR_CNT && s.sync_seen) begin
      next_s.lcd_def = 1'b0;
    end

    // error count queue toward transmit
    if (I_TX_FRAME) begin
      next_s.g1 = {(s.rei_full ? s.rei_val : 4'h0), tx_code, 1'b0};
      next_s.rei_full = 1'b0;
    end
    if (push) begin
      next_s.rei_full = 1'b1;
      next_s.rei_val = rei_in;
    end

    next_s.irq_a = |(next_s.pend & wps_mask_ext(next_s.mask_a));
    next_s.irq_b = |(next_s.pend & wps_mask_ext(next_s.mask_b));
  end

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      s <= '0;
      s.ctrl <= CTRL_RST;
      s.lcd_def <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign O_RDATA = s.rdata;
  assign O_TX_OH = {s.g1, s.f2, s.h4, s.z3, s.z4, s.n1};
  assign O_LCD_REPORT = s.lcd_def;
  assign O_IRQ_A = s.irq_a;
  assign O_IRQ_B = s.irq_b;

  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (!I_RST_N);

  one_bit_tx_a: assert property (I_TX_FRAME && !s.ctrl[C_TXFMT]
    |=> O_TX_OH.g1[2:0] == 3'h0 && O_TX_OH.g1[G1_RDI_BIT] == $past(I_NE_DEFECT.server))
    else $error("one-bit transmit status bits wrong");
  server_first_a: assert property (I_TX_FRAME && s.ctrl[C_TXFMT] && I_NE_DEFECT.server
    |=> O_TX_OH.g1[G1_RDI_BIT:1] == CODE_SRV)
    else $error("server defect not sent with top priority");
  trace_force_a: assert property (I_TX_FRAME && s.ctrl[C_TXFMT] && !I_NE_DEFECT.server
    && !I_NE_DEFECT.unequipped && !s.ctrl[C_TIM] |=> O_TX_OH.g1[G1_RDI_BIT:1] != CODE_CON)
    else $error("connectivity code sent without cause");
  rei_empty_a: assert property (I_TX_FRAME && !s.rei_full
    |=> O_TX_OH.g1[7:4] == 4'h0)
    else $error("error count sent from empty queue");
  rei_range_a: assert property (I_TX_FRAME |=> O_TX_OH.g1[7:4] <= REI_MAX)
    else $error("error count above eight");
  rdi_declare_a: assert property ($rose(s.rdi_def) |-> s.on_cnt == PERSIST_FRAMES)
    else $error("defect declared before ten frames");
  rdi_clear_a: assert property ($fell(s.rdi_def) |-> s.off_cnt == PERSIST_FRAMES)
    else $error("defect cleared before ten frames");
  pend_hold_a: assert property (s.pend[E_RDI] && !rd_pend |=> s.pend[E_RDI])
    else $error("pending bit lost before read");
  payload_event_a: assert property ($rose(s.lat_pay) |-> s.pend[E_PAY] && s.def_code == CODE_PAY)
    else $error("payload defect latch without pending");
  server_event_a: assert property ($rose(s.lat_srv) |-> s.pend[E_SRV] && s.def_code == CODE_SRV)
    else $error("server defect latch without pending");
  conn_live_a: assert property ($rose(s.pend[E_CON]) |-> con_live)
    else $error("connectivity pending without live bit");
  lcd_set_a: assert property ($rose(s.lcd_def) |-> $past(s.lcd_cnt) == SET_CNT && $past(I_PCS_LCD))
    else $error("delineation loss reported too early");
  lcd_clear_a: assert property ($fell(s.lcd_def) |-> $past(s.sync_seen) && !$past(I_PCS_LCD))
    else $error("delineation loss dropped too early");
  lcd_latch_a: assert property (I_PCS_LCD |=> s.lat_lcd && s.pend[E_LCD])
    else $error("delineation alarm not latched");
  pay_pend_hold_a: assert property (s.pend[E_PAY] && !rd_pend |=> s.pend[E_PAY])
    else $error("payload pending bit lost before read");
  srv_pend_hold_a: assert property (s.pend[E_SRV] && !rd_pend |=> s.pend[E_SRV])
    else $error("server pending bit lost before read");
  con_pend_hold_a: assert property (s.pend[E_CON] && !rd_pend |=> s.pend[E_CON])
    else $error("connectivity pending bit lost before read");
  lcd_pend_hold_a: assert property (s.pend[E_LCD] && !rd_pend |=> s.pend[E_LCD])
    else $error("delineation pending bit lost before read");
  pay_stat_hold_a: assert property (s.lat_pay && !rd_stat |=> s.lat_pay)
    else $error("payload status latch lost before read");
  srv_stat_hold_a: assert property (s.lat_srv && !rd_stat |=> s.lat_srv)
    else $error("server status latch lost before read");
  lcd_stat_hold_a: assert property (s.lat_lcd && !rd_stat |=> s.lat_lcd)
    else $error("delineation status latch lost before read");
  irq_quiet_a: assert property (s.pend == '0 |-> !O_IRQ_A && !O_IRQ_B)
    else $error("interrupt raised with nothing pending");
  srv_irq_a: assert property (s.pend[E_SRV] && s.mask_a[E_SRV] |-> O_IRQ_A)
    else $error("server event not on interrupt a");
  con_irq_a: assert property (s.pend[E_CON] && s.mask_b[E_RDI] |-> O_IRQ_B)
    else $error("connectivity event not on interrupt b");
  lcd_irq_a: assert property (s.pend[E_LCD] && s.mask_b[E_LCD] |-> O_IRQ_B)
    else $error("delineation event not on interrupt b");
  sync_report_a: assert property (!s.sync_seen |-> O_LCD_REPORT)
    else $error("delineation loss report dropped before sync");
  lcd_hold_a: assert property (s.lcd_def && I_PCS_LCD |=> s.lcd_def)
    else $error("delineation loss report dropped while alarm present");
  idle_code_a: assert property (I_TX_FRAME && s.ctrl[C_TXFMT] && I_NE_DEFECT == '0
    && !s.ctrl[C_TIM] && !s.lcd_def |=> O_TX_OH.g1[G1_RDI_BIT:1] == CODE_OK)
    else $error("no-defect code wrong");
  payload_tx_a: assert property (I_TX_FRAME && s.ctrl[C_TXFMT] && !I_NE_DEFECT.server
    && !I_NE_DEFECT.unequipped && !s.ctrl[C_TIM] && (I_NE_DEFECT.label_mismatch || s.lcd_def)
    |=> O_TX_OH.g1[G1_RDI_BIT:1] == CODE_PAY)
    else $error("payload defect code not sent");
  conn_tx_a: assert property (I_TX_FRAME && s.ctrl[C_TXFMT] && !I_NE_DEFECT.server
    && (I_NE_DEFECT.unequipped || s.ctrl[C_TIM]) |=> O_TX_OH.g1[G1_RDI_BIT:1] == CODE_CON)
    else $error("connectivity defect code not sent");
  user_octet_a: assert property (I_WR && I_ADDR == A_USER
    |=> O_TX_OH.f2 == $past(I_WDATA[7:0]) && O_TX_OH.h4 == $past(I_WDATA[15:8]))
    else $error("user channel or multiframe octet not taken");
  growth_octet_a: assert property (I_WR && I_ADDR == A_GROWTH
    |=> O_TX_OH.z3 == $past(I_WDATA[7:0]) && O_TX_OH.z4 == $past(I_WDATA[15:8]))
    else $error("growth octets not taken");
  no_defect_code_a: assert property (I_RX_G1_VALID && s.ctrl[C_RXFMT] && !I_RX_G1[G1_RDI_BIT]
    && I_RX_G1[G1_RDI_BIT-1:1] != CODE_PAY[1:0] |=> s.on_cnt == '0)
    else $error("no-defect code counted as defect");
  one_bit_seen_a: assert property (I_RX_G1_VALID && !s.ctrl[C_RXFMT] && I_RX_G1[G1_RDI_BIT]
    |=> s.cand == CODE_RDI && s.off_cnt == '0)
    else $error("one-bit defect flag not counted");
  one_bit_gone_a: assert property (I_RX_G1_VALID && !s.ctrl[C_RXFMT] && !I_RX_G1[G1_RDI_BIT]
    |=> s.on_cnt == '0)
    else $error("absent one-bit flag still counted");

  declare_c: cover property ($rose(s.rdi_def));
  clear_c: cover property ($fell(s.rdi_def));
  lcd_c: cover property ($fell(s.lcd_def));
  irq_c: cover property ($rose(s.irq_a) ##[1:20] rd_pend);
  lcd_set_c: cover property ($rose(s.lcd_def));
endmodule : wps_path_status
`default_nettype wire

// >>> verif/wps_far_end.sv
// far-end path terminating equipment sending path status octets
`default_nettype none
module wps_far_end
  import wps_pkg::*;
(
  input wire logic i_clk,
  output logic o_valid,
  output logic [7:0] o_g1
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_valid = 1'b0;
    o_g1 = 8'h00;
  end
  // one octet per frame; spare bit toggles since the receiver ignores it
  task automatic send(input logic [2:0] code, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge i_clk);
      o_valid <= 1'b1;
      o_g1 <= {4'h3, code, i[0]};
      @(posedge i_clk);
      o_valid <= 1'b0;
      o_g1 <= ~o_g1;
      repeat (2) @(posedge i_clk);
    end
  endtask : send
endmodule : wps_far_end
`default_nettype wire

// >>> verif/tb_top.sv
// bench for the path status overhead block
`default_nettype none
module tb_top
  import wps_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, wr, rd, g1v, reiv, txf, lcd, sync, lcd_rep, irq_a, irq_b;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata, rdata;
  logic [7:0] g1;
  logic [3:0] rei_cnt;
  wps_ne_s ne;
  wps_tx_oh_s oh;
  int mismatches = 0;
  int n_tests = 0;
  // ctrl, near-end defects {server, unequipped, label}, sent code
  localparam logic [8:0] TX_TAB [7] = '{{3'h3, 3'b000, 3'h1}, {3'h3, 3'b001, 3'h2}, {3'h3, 3'b011, 3'h6},
    {3'h3, 3'b111, 3'h5}, {3'h7, 3'b001, 3'h6}, {3'h1, 3'b100, 3'h4}, {3'h1, 3'b011, 3'h0}};

  wps_path_status #(.P_SET_CYC(30), .P_CLR_CYC(10)) uut (.I_CLK(clk), .I_RST_N(rst_n), .I_ADDR(addr),
    .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_RX_G1_VALID(g1v), .I_RX_G1(g1),
    .I_REI_VALID(reiv), .I_REI_CNT(rei_cnt), .I_TX_FRAME(txf), .I_NE_DEFECT(ne), .I_PCS_LCD(lcd),
    .I_PCS_SYNC(sync), .O_TX_OH(oh), .O_LCD_REPORT(lcd_rep), .O_IRQ_A(irq_a), .O_IRQ_B(irq_b));
  wps_far_end far (.i_clk(clk), .o_valid(g1v), .o_g1(g1));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  task automatic wr_reg(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [AW-1:0] a, input logic [DW-1:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask : rd_reg

  task automatic tx_frame(input logic [2:0] d);
    @(posedge clk);
    ne <= d;
    txf <= 1'b1;
    @(posedge clk);
    txf <= 1'b0;
    #1;
  endtask : tx_frame

  // n counts offered on every other cycle before one transmitted frame
  task automatic rei_case(input int n, input logic [3:0] v, input logic [3:0] e);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      reiv <= 1'b1;
      rei_cnt <= v + 4'(i);
      @(posedge clk);
      reiv <= 1'b0;
    end
    tx_frame(3'b000);
    chk({12'h0, oh.g1[7:4]}, {12'h0, e});
  endtask : rei_case

  task automatic rx_case(input logic [2:0] c, input int n, input logic [15:0] s, input logic [15:0] p);
    far.send(c, n);
    rd_reg(A_STAT, s);
    rd_reg(A_PEND, p);
  endtask : rx_case

  initial begin
    #200us;
    mismatches++;
    report_and_stop();
  end

  initial begin
    rst_n = 1'b0;
    {wr, rd, reiv, txf, lcd, sync} = 6'h00;
    addr = 8'h00;
    wdata = 16'h0000;
    rei_cnt = 4'h0;
    ne = 3'b000;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    cyc(40);
    chk(16'(lcd_rep), 16'h1);
    rd_reg(A_CTRL, 16'h0003);
    rd_reg(A_MASKA, 16'h0000);
    wr_reg(A_MASKA, 16'h001f);
    rd_reg(A_MASKA, 16'h0017);
    rd_reg(8'h20, 16'h0000);
    @(posedge clk);
    sync <= 1'b1;
    cyc(15);
    chk(16'(lcd_rep), 16'h0);
    wr_reg(A_USER, 16'ha55a);
    wr_reg(A_TANDEM, 16'h0033);
    wr_reg(A_GROWTH, 16'hc3e1);
    cyc(1);
    chk({oh.h4, oh.f2}, 16'ha55a);
    chk({8'h00, oh.n1}, 16'h0033);
    chk({oh.z4, oh.z3}, 16'hc3e1);
    foreach (TX_TAB[i]) begin
      wr_reg(A_CTRL, {13'h0, TX_TAB[i][8:6]});
      tx_frame(TX_TAB[i][5:3]);
      chk({13'h0, oh.g1[3:1]}, {13'h0, TX_TAB[i][2:0]});
    end
    wr_reg(A_CTRL, 16'h0003);
    rei_case(0, 4'h0, 4'h0);
    rei_case(1, 4'h5, 4'h5);
    rei_case(2, 4'h6, 4'h6);
    rei_case(0, 4'h0, 4'h0);
    rei_case(1, 4'hc, 4'h8);
    wr_reg(A_MASKA, 16'h0004);
    rx_case(3'h5, 9, 16'h0000, 16'h0000);
    far.send(3'h5, 1);
    cyc(1);
    chk(16'(irq_a), 16'h1);
    rx_case(3'h5, 0, 16'h0005, 16'h0005);
    cyc(2);
    chk(16'(irq_a), 16'h0);
    rx_case(3'h1, 10, 16'h0000, 16'h0000);
    rx_case(3'h2, 10, 16'h0003, 16'h0003);
    rx_case(3'h3, 10, 16'h0000, 16'h0000);
    wr_reg(A_MASKB, 16'h0001);
    far.send(3'h6, 10);
    cyc(1);
    chk(16'(irq_b), 16'h1);
    chk(16'(irq_a), 16'h0);
    rx_case(3'h6, 0, 16'h0009, 16'h0009);
    rx_case(3'h0, 10, 16'h0000, 16'h0000);
    rx_case(3'h4, 10, 16'h0000, 16'h0000);
    wr_reg(A_CTRL, 16'h0002);
    far.send(3'h7, 5);
    rx_case(3'h4, 5, 16'h0001, 16'h0001);
    rx_case(3'h2, 10, 16'h0000, 16'h0000);
    wr_reg(A_MASKB, 16'h0010);
    lcd <= 1'b1;
    cyc(20);
    chk(16'(lcd_rep), 16'h0);
    cyc(20);
    chk(16'(lcd_rep), 16'h1);
    chk(16'(irq_b), 16'h1);
    @(posedge clk);
    lcd <= 1'b0;
    cyc(5);
    chk(16'(lcd_rep), 16'h1);
    cyc(10);
    chk(16'(lcd_rep), 16'h0);
    rd_reg(A_STAT, 16'h0010);
    rd_reg(A_PEND, 16'h0010);
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
